//--- verilog/bcx_exec.sv
// Contract
// RL1: mask-off ANDs register with inverted mask; updates Z, N, V; one cycle.
// RL2: plus or minus one; updates Z, N, V; carry kept; one cycle.
// RL3: zero-or-sign check keeps value, updates Z, N, V in one cycle.
// RL4: zeroing updates Z, N, V; fill loads ones, no flags; both one cycle.
// RL5: relative goto/entry: pc plus offset plus one; two or three cycles.
// RL6: pointer goto/entry load pc from Z pointer; 2 or 3 cycles; no flags.
// RL7: absolute goto/entry load pc from constant; 3 or 4 cycles; no flags.
// RL8: exits restore pc from stack in four cycles; handler exit sets I.
// RL9: equal compare skip skips next when equal; pc plus 2 or 3.
// RL10: flag-only subtracts update Z, N, V, C, H without storing result.
// RL11: register bit skips on bit low or high; 1, 2 or 3 cycles.
// RL12: I/O bit skips on I/O bit low or high; 1, 2 or 3 cycles.
// RL13: status-bit branches add offset plus one when chosen bit matches.
// RL14: equal/unequal test Z; carry and unsigned branches test C.
// RL15: negative branch on N set, nonnegative branch on N clear.
// RL16: signed at-least when N xor V is 0, below when 1.
// RL17: half-carry branches test H set or clear; 1 or 2 cycles.
// RL18: transfer-bit branches test T set or clear; 1 or 2 cycles.
// RL19: overflow branches test V set or clear; 1 or 2 cycles.
// RL20: interrupt-state branches test I set or clear; 1 or 2 cycles.
// RL21: I/O bit set or clear writes one bit in two cycles; no flags.
// RL22: single-bit I/O operations accepted only for addresses 0x00 to 0x1f.
// RL23: I/O bit operations touch only the addressed bit, never others.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "bcx_consts.svh"
module bcx_exec (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic             op_valid_i,
  input  wire bcx_pkg::bcx_op_t op_i,
  input  wire bcx_pkg::bcx_br_t br_sel_i,
  input  wire logic [7:0]       rd_val_i,
  input  wire logic [7:0]       rr_val_i,
  input  wire logic [7:0]       imm_i,
  input  wire logic [2:0]       bit_i,
  input  wire logic [5:0]       io_addr_i,
  input  wire logic [11:0]      offset_i,
  input  wire logic [15:0]      target_i,
  input  wire logic [15:0]      z_ptr_i,
  input  wire logic [15:0]      stack_i,
  input  wire logic             next_two_word_i,
  output logic                  op_ready_o,
  output logic                  done_o,
  output logic      [7:0]       result_o,
  output logic                  result_we_o,
  output logic      [15:0]      pc_o,
  output logic      [7:0]       status_flags_register_o,
  output logic                  push_o,
  output logic                  pop_o,
  output logic      [15:0]      ret_addr_o,
  output logic                  io_we_o,
  output logic      [4:0]       io_waddr_o,
  output logic      [7:0]       io_wmask_o,
  output logic      [7:0]       io_wval_o
);

  bcx_pkg::bcx_state_t st_ff;
  bcx_pkg::bcx_state_t nxt_st;
  logic                accept;
  logic                apb_wr;
  logic [2:0]          cyc;
  logic [7:0]          res;
  logic [15:0]         rel_pc;
  logic                skip;
  logic [4:0]          io_idx;
  logic [7:0]          bmask;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) &&
             ((a <= `BCX_OFF_IO_END) || (a == `BCX_OFF_FLAGS) ||
              (a == `BCX_OFF_PC) || (a == `BCX_OFF_ERR));
  endfunction

  // logic-style flags: Z, N, V only
  function automatic logic [7:0] znv(input logic [7:0] s,
                                     input logic [7:0] r);
    znv = s;
    znv[`BCX_FLAG_Z] = (r == 8'h00);
    znv[`BCX_FLAG_N] = r[7];
    znv[`BCX_FLAG_V] = 1'b0;
  endfunction

  function automatic logic [7:0] cmp(input logic [7:0] s,
                                     input logic [7:0] d,
                                     input logic [7:0] k,
                                     input logic       with_c);
    logic [7:0] r;
    r = d - k - {7'h00, with_c & s[`BCX_FLAG_C]};
    cmp = s;
    cmp[`BCX_FLAG_Z] = (r == 8'h00) & (~with_c | s[`BCX_FLAG_Z]);
    cmp[`BCX_FLAG_N] = r[7];
    cmp[`BCX_FLAG_V] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
    cmp[`BCX_FLAG_C] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
    cmp[`BCX_FLAG_H] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
  endfunction

  function automatic logic br_cond(input bcx_pkg::bcx_br_t b,
                                   input logic [2:0]       n,
                                   input logic [7:0]       s);
    case (b)
      bcx_pkg::branch_on_status_bit_high:   br_cond = s[n];
      bcx_pkg::branch_on_status_bit_low:    br_cond = ~s[n];
      bcx_pkg::branch_on_equal:             br_cond = s[`BCX_FLAG_Z];
      bcx_pkg::branch_on_unequal:           br_cond = ~s[`BCX_FLAG_Z];
      bcx_pkg::branch_on_carry_high:        br_cond = s[`BCX_FLAG_C];
      bcx_pkg::branch_on_carry_low:         br_cond = ~s[`BCX_FLAG_C];
      bcx_pkg::branch_unsigned_at_least:    br_cond = ~s[`BCX_FLAG_C];
      bcx_pkg::branch_unsigned_below:       br_cond = s[`BCX_FLAG_C];
      bcx_pkg::branch_on_negative:          br_cond = s[`BCX_FLAG_N];
      bcx_pkg::branch_on_nonnegative:       br_cond = ~s[`BCX_FLAG_N];
      bcx_pkg::branch_signed_at_least:
        br_cond = ~(s[`BCX_FLAG_N] ^ s[`BCX_FLAG_V]);
      bcx_pkg::branch_signed_below:
        br_cond = s[`BCX_FLAG_N] ^ s[`BCX_FLAG_V];
      bcx_pkg::branch_on_half_carry_high:   br_cond = s[`BCX_FLAG_H];
      bcx_pkg::branch_on_half_carry_low:    br_cond = ~s[`BCX_FLAG_H];
      bcx_pkg::branch_on_transfer_bit_high: br_cond = s[`BCX_FLAG_T];
      bcx_pkg::branch_on_transfer_bit_low:  br_cond = ~s[`BCX_FLAG_T];
      bcx_pkg::branch_on_overflow_high:     br_cond = s[`BCX_FLAG_V];
      bcx_pkg::branch_on_overflow_low:      br_cond = ~s[`BCX_FLAG_V];
      bcx_pkg::branch_on_irq_enabled:       br_cond = s[`BCX_FLAG_I];
      bcx_pkg::branch_on_irq_disabled:      br_cond = ~s[`BCX_FLAG_I];
      default:                              br_cond = 1'b0;
    endcase
  endfunction

  assign accept    = op_valid_i && op_ready_o;
  assign apb_wr    = psel_i && penable_i && pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
  assign rel_pc    = 16'(st_ff.pc + {{4{offset_i[11]}}, offset_i} + 16'h1);
  assign io_idx    = io_addr_i[4:0];
  assign bmask     = 8'(8'h01 << bit_i);

  always_comb begin
    nxt_st           = st_ff;
    cyc              = `BCX_CYC_ONE;
    res              = rd_val_i;
    skip             = 1'b0;
    nxt_st.done      = 1'b0;
    nxt_st.result_we = 1'b0;
    nxt_st.push      = 1'b0;
    nxt_st.pop       = 1'b0;
    nxt_st.io_we     = 1'b0;
    if (st_ff.cnt != 2'h0) begin
      nxt_st.cnt = st_ff.cnt - 2'h1;
    end
    if (psel_i && !penable_i) begin
      nxt_st.rdata = 32'h0000_0000;
      if (paddr_i <= `BCX_OFF_IO_END) begin
        nxt_st.rdata[7:0] = st_ff.io[paddr_i[6:2]];
      end else if (paddr_i == `BCX_OFF_FLAGS) begin
        nxt_st.rdata[7:0] = st_ff.status_flags_register;
      end else if (paddr_i == `BCX_OFF_PC) begin
        nxt_st.rdata[15:0] = st_ff.pc;
      end else if (paddr_i == `BCX_OFF_ERR) begin
        nxt_st.rdata[0] = st_ff.err;
      end
    end
    if (apb_wr && mapped(paddr_i)) begin
      if (paddr_i <= `BCX_OFF_IO_END) begin
        nxt_st.io[paddr_i[6:2]] = pwdata_i[7:0];
      end else if (paddr_i == `BCX_OFF_FLAGS) begin
        nxt_st.status_flags_register = pwdata_i[7:0];
      end else if (paddr_i == `BCX_OFF_ERR && pwdata_i[0]) begin
        nxt_st.err = 1'b0;
      end
    end
    if (accept) begin
      nxt_st.pc   = 16'(st_ff.pc + 16'h1);
      nxt_st.done = 1'b1;
      case (op_i)
        bcx_pkg::mask_off_register_bits: begin
          res = rd_val_i & (`BCX_ALL_ONES - imm_i); // RL1
          nxt_st.status_flags_register = znv(st_ff.status_flags_register, res); // RL1
          nxt_st.result_we = 1'b1;
        end
        bcx_pkg::add_one, bcx_pkg::subtract_one: begin
          res = (op_i == bcx_pkg::add_one) ? 8'(rd_val_i + 8'h01) :
                                             8'(rd_val_i - 8'h01); // RL2
          nxt_st.status_flags_register = znv(st_ff.status_flags_register, res); // RL2
          nxt_st.status_flags_register[`BCX_FLAG_V] = (op_i == bcx_pkg::add_one) ?
                                     (res == 8'h80) : (res == 8'h7f); // RL2
          nxt_st.result_we = 1'b1;
        end
        bcx_pkg::zero_or_sign_check: begin
          res = rd_val_i & rd_val_i; // RL3
          nxt_st.status_flags_register = znv(st_ff.status_flags_register, res); // RL3
        end
        bcx_pkg::zero_register: begin
          res = rd_val_i ^ rd_val_i; // RL4
          nxt_st.status_flags_register = znv(st_ff.status_flags_register, res); // RL4
          nxt_st.result_we = 1'b1;
        end
        bcx_pkg::fill_register_with_ones: begin
          res = `BCX_ALL_ONES; // RL4
          nxt_st.result_we = 1'b1;
        end
        bcx_pkg::relative_goto, bcx_pkg::relative_subroutine_entry: begin
          nxt_st.pc = rel_pc; // RL5
          nxt_st.push = (op_i == bcx_pkg::relative_subroutine_entry);
          nxt_st.ret_addr = 16'(st_ff.pc + 16'h1);
          cyc = (op_i == bcx_pkg::relative_goto) ?
                `BCX_CYC_TWO : `BCX_CYC_THREE; // RL5
        end
        bcx_pkg::pointer_goto, bcx_pkg::pointer_subroutine_entry: begin
          nxt_st.pc = z_ptr_i; // RL6
          nxt_st.push = (op_i == bcx_pkg::pointer_subroutine_entry);
          nxt_st.ret_addr = 16'(st_ff.pc + 16'h1);
          cyc = (op_i == bcx_pkg::pointer_goto) ?
                `BCX_CYC_TWO : `BCX_CYC_THREE; // RL6
        end
        bcx_pkg::absolute_goto, bcx_pkg::absolute_subroutine_entry: begin
          nxt_st.pc = target_i; // RL7
          nxt_st.push = (op_i == bcx_pkg::absolute_subroutine_entry);
          nxt_st.ret_addr = 16'(st_ff.pc + 16'h2);
          cyc = (op_i == bcx_pkg::absolute_goto) ?
                `BCX_CYC_THREE : `BCX_CYC_FOUR; // RL7
        end
        bcx_pkg::subroutine_exit, bcx_pkg::handler_exit: begin
          nxt_st.pc = stack_i; // RL8
          nxt_st.pop = 1'b1;
          cyc = `BCX_CYC_FOUR; // RL8
          if (op_i == bcx_pkg::handler_exit) begin
            nxt_st.status_flags_register[`BCX_FLAG_I] = 1'b1; // RL8
          end
        end
        bcx_pkg::equal_compare_skip: begin
          skip = (rd_val_i == rr_val_i); // RL9
        end
        bcx_pkg::flag_only_subtract: begin
          nxt_st.status_flags_register = cmp(st_ff.status_flags_register, rd_val_i, rr_val_i, 1'b0); // RL10
        end
        bcx_pkg::flag_only_subtract_with_borrow: begin
          nxt_st.status_flags_register = cmp(st_ff.status_flags_register, rd_val_i, rr_val_i, 1'b1); // RL10
        end
        bcx_pkg::flag_only_subtract_immediate: begin
          nxt_st.status_flags_register = cmp(st_ff.status_flags_register, rd_val_i, imm_i, 1'b0); // RL10
        end
        bcx_pkg::skip_on_reg_bit_low: begin
          skip = ~rr_val_i[bit_i]; // RL11
        end
        bcx_pkg::skip_on_reg_bit_high: begin
          skip = rr_val_i[bit_i]; // RL11
        end
        bcx_pkg::skip_on_io_bit_low, bcx_pkg::skip_on_io_bit_high: begin
          if (io_addr_i < `BCX_IO_LIMIT) begin
            skip = st_ff.io[io_idx][bit_i] ^
                   (op_i == bcx_pkg::skip_on_io_bit_low); // RL12
          end else begin
            nxt_st.err = 1'b1; // RL22
          end
        end
        bcx_pkg::conditional_branch: begin
          if (br_cond(br_sel_i, bit_i, st_ff.status_flags_register)) begin
            nxt_st.pc = rel_pc; // RL13 RL14 RL15 RL16 RL17
            cyc = `BCX_CYC_TWO; // RL18 RL19 RL20
          end
        end
        bcx_pkg::io_bit_set, bcx_pkg::io_bit_clear: begin
          if (io_addr_i < `BCX_IO_LIMIT) begin
            nxt_st.io[io_idx][bit_i] = (op_i == bcx_pkg::io_bit_set); // RL21
            nxt_st.io_we = 1'b1;
            nxt_st.io_waddr = io_idx;
            nxt_st.io_wmask = bmask; // RL23
            nxt_st.io_wval = nxt_st.io[io_idx];
            cyc = `BCX_CYC_TWO; // RL21
          end else begin
            nxt_st.err = 1'b1; // RL22
          end
        end
        default: begin
        end
      endcase
      if (skip) begin
        cyc = next_two_word_i ? `BCX_CYC_THREE : `BCX_CYC_TWO; // RL9 RL11 RL12
        nxt_st.pc = 16'(st_ff.pc + {13'h0000, cyc});
      end
      nxt_st.result = res;
      nxt_st.cnt = 2'(cyc - `BCX_CYC_ONE);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.pc <= `BCX_PC_RST;
      st_ff.status_flags_register <= `BCX_STATUS_FLAGS_REGISTER_RST;
      st_ff.io <= {32{`BCX_IO_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign op_ready_o  = (st_ff.cnt == 2'h0);
  assign prdata_o    = st_ff.rdata;
  assign done_o      = st_ff.done;
  assign result_o    = st_ff.result;
  assign result_we_o = st_ff.result_we;
  assign pc_o        = st_ff.pc;
  assign status_flags_register_o      = st_ff.status_flags_register;
  assign push_o      = st_ff.push;
  assign pop_o       = st_ff.pop;
  assign ret_addr_o  = st_ff.ret_addr;
  assign io_we_o     = st_ff.io_we;
  assign io_waddr_o  = st_ff.io_waddr;
  assign io_wmask_o  = st_ff.io_wmask;
  assign io_wval_o   = st_ff.io_wval;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_mask_off;
    accept && op_i == bcx_pkg::mask_off_register_bits |=>
      result_we_o && result_o == ($past(rd_val_i) & ~$past(imm_i));
  endproperty
  a_mask_off: assert property (p_mask_off) // RL1
    else $error("mask-off result wrong");

  property p_add_one;
    accept && op_i == bcx_pkg::add_one |=>
      result_o == 8'($past(rd_val_i) + 8'h01) &&
      status_flags_register_o[`BCX_FLAG_C] == $past(status_flags_register_o[`BCX_FLAG_C]);
  endproperty
  a_add_one: assert property (p_add_one) // RL2
    else $error("add-one result or carry wrong");

  property p_check;
    accept && op_i == bcx_pkg::zero_or_sign_check |=>
      !result_we_o && status_flags_register_o[`BCX_FLAG_Z] == ($past(rd_val_i) == 8'h00);
  endproperty
  a_check: assert property (p_check) // RL3
    else $error("zero-or-sign check wrong");

  property p_fill;
    accept && op_i == bcx_pkg::fill_register_with_ones && !apb_wr |=>
      result_o == 8'hff && status_flags_register_o == $past(status_flags_register_o) && op_ready_o;
  endproperty
  a_fill: assert property (p_fill) // RL4
    else $error("fill changed flags or value");

  property p_rel;
    accept && op_i == bcx_pkg::relative_goto |=>
      pc_o == 16'($past(pc_o) + {{4{$past(offset_i[11])}},
                                 $past(offset_i)} + 16'h1)
      ##0 !op_ready_o ##1 op_ready_o;
  endproperty
  a_rel: assert property (p_rel) // RL5
    else $error("relative goto pc or timing wrong");

  property p_ptr;
    accept && op_i == bcx_pkg::pointer_subroutine_entry |=>
      pc_o == $past(z_ptr_i) && push_o ##0 !op_ready_o[*2] ##1 op_ready_o;
  endproperty
  a_ptr: assert property (p_ptr) // RL6
    else $error("pointer entry wrong");

  property p_abs;
    accept && op_i == bcx_pkg::absolute_goto |=>
      pc_o == $past(target_i) ##0 !op_ready_o[*2] ##1 op_ready_o;
  endproperty
  a_abs: assert property (p_abs) // RL7
    else $error("absolute goto wrong");

  property p_exit;
    accept && op_i == bcx_pkg::handler_exit |=>
      pc_o == $past(stack_i) && status_flags_register_o[`BCX_FLAG_I]
      ##0 !op_ready_o[*3] ##1 op_ready_o;
  endproperty
  a_exit: assert property (p_exit) // RL8
    else $error("handler exit wrong");

  property p_skip;
    accept && op_i == bcx_pkg::equal_compare_skip &&
    rd_val_i == rr_val_i && next_two_word_i |=>
      pc_o == 16'($past(pc_o) + 16'h3);
  endproperty
  a_skip: assert property (p_skip) // RL9
    else $error("compare skip pc wrong");

  property p_signed;
    accept && op_i == bcx_pkg::conditional_branch &&
    br_sel_i == bcx_pkg::branch_signed_below &&
    (status_flags_register_o[`BCX_FLAG_N] == status_flags_register_o[`BCX_FLAG_V]) |=>
      pc_o == 16'($past(pc_o) + 16'h1) && op_ready_o;
  endproperty
  a_signed: assert property (p_signed) // RL16
    else $error("signed below taken wrongly");

  property p_io_one_bit;
    accept && op_i == bcx_pkg::io_bit_set && io_addr_i < `BCX_IO_LIMIT |=>
      io_we_o && io_wmask_o == 8'(8'h01 << $past(bit_i)) &&
      io_wval_o[$past(bit_i)];
  endproperty
  a_io_one_bit: assert property (p_io_one_bit) // RL21
    else $error("io bit set wrong");

  property p_io_range;
    accept && op_i == bcx_pkg::io_bit_clear && io_addr_i[5] |=>
      !io_we_o && op_ready_o;
  endproperty
  a_io_range: assert property (p_io_range) // RL22
    else $error("io op above range accepted");

  c_taken: cover property (accept && op_i == bcx_pkg::conditional_branch
                           ##1 !op_ready_o);
  c_skip3: cover property (accept && op_i == bcx_pkg::skip_on_reg_bit_high
                           ##1 !op_ready_o[*2]);
  c_call4: cover property (accept &&
                           op_i == bcx_pkg::absolute_subroutine_entry);

endmodule

//--- include/bcx_consts.svh
`ifndef BCX_CONSTS_SVH
`define BCX_CONSTS_SVH

`define BCX_FLAG_C      0
`define BCX_FLAG_Z      1
`define BCX_FLAG_N      2
`define BCX_FLAG_V      3
`define BCX_FLAG_S      4
`define BCX_FLAG_H      5
`define BCX_FLAG_T      6
`define BCX_FLAG_I      7

`define BCX_ALL_ONES    8'hff
`define BCX_STATUS_FLAGS_REGISTER_RST    8'h00
`define BCX_PC_RST      16'h0000
`define BCX_IO_RST      8'h00
`define BCX_IO_LIMIT    6'h20

`define BCX_CYC_ONE     3'h1
`define BCX_CYC_TWO     3'h2
`define BCX_CYC_THREE   3'h3
`define BCX_CYC_FOUR    3'h4

`define BCX_OFF_IO_BASE 12'h000
`define BCX_OFF_IO_END  12'h07c
`define BCX_OFF_FLAGS   12'h080
`define BCX_OFF_PC      12'h084
`define BCX_OFF_ERR     12'h088

`endif

//--- include/bcx_pkg.sv
package bcx_pkg;

  typedef enum logic [4:0] {
    op_none,
    mask_off_register_bits,
    add_one,
    subtract_one,
    zero_or_sign_check,
    zero_register,
    fill_register_with_ones,
    relative_goto,
    pointer_goto,
    absolute_goto,
    relative_subroutine_entry,
    pointer_subroutine_entry,
    absolute_subroutine_entry,
    subroutine_exit,
    handler_exit,
    equal_compare_skip,
    flag_only_subtract,
    flag_only_subtract_with_borrow,
    flag_only_subtract_immediate,
    skip_on_reg_bit_low,
    skip_on_reg_bit_high,
    skip_on_io_bit_low,
    skip_on_io_bit_high,
    conditional_branch,
    io_bit_set,
    io_bit_clear
  } bcx_op_t;

  typedef enum logic [4:0] {
    branch_on_status_bit_high,
    branch_on_status_bit_low,
    branch_on_equal,
    branch_on_unequal,
    branch_on_carry_high,
    branch_on_carry_low,
    branch_unsigned_at_least,
    branch_unsigned_below,
    branch_on_negative,
    branch_on_nonnegative,
    branch_signed_at_least,
    branch_signed_below,
    branch_on_half_carry_high,
    branch_on_half_carry_low,
    branch_on_transfer_bit_high,
    branch_on_transfer_bit_low,
    branch_on_overflow_high,
    branch_on_overflow_low,
    branch_on_irq_enabled,
    branch_on_irq_disabled
  } bcx_br_t;

  typedef struct packed {
    logic [15:0]       pc;
    logic [7:0]        status_flags_register;
    logic [31:0][7:0]  io;
    logic [1:0]        cnt;
    logic [7:0]        result;
    logic              result_we;
    logic              done;
    logic              push;
    logic              pop;
    logic [15:0]       ret_addr;
    logic              io_we;
    logic [4:0]        io_waddr;
    logic [7:0]        io_wmask;
    logic [7:0]        io_wval;
    logic              err;
    logic [31:0]       rdata;
  } bcx_state_t;

endpackage

//--- testbench/bcx_stack_model.sv
`timescale 1ns/1ns
module bcx_stack_model (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [15:0] ret_addr_i,
  output logic      [15:0] top_o
);
  logic [15:0] mem_ff [8];
  logic [2:0]  sp_ff;

  // last-in first-out return addresses
  assign top_o = mem_ff[sp_ff - 3'h1];

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sp_ff <= 3'h0;
    end else if (push_i) begin
      mem_ff[sp_ff] <= ret_addr_i;
      sp_ff         <= sp_ff + 3'h1;
    end else if (pop_i) begin
      sp_ff <= sp_ff - 3'h1;
    end
  end
endmodule

//--- testbench/bcx_exec_test.sv
`timescale 1ns/1ns
module bcx_exec_test;
  typedef struct packed {
    bcx_pkg::bcx_op_t op;
    logic [7:0]       d;
    logic [7:0]       k;
    logic [3:0]       b;
    logic [7:0]       io;
    logic [15:0]      t;
    logic [7:0]       fl;
    logic [3:0]       ntw;
    logic [15:0]      pc;
    logic [7:0]       res;
    logic [3:0]       we;
    logic [7:0]       sr;
    logic [3:0]       cyc;
  } bcx_row_t;
  logic clock_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, op_valid_i = 1'b0, next_two_word_i = 1'b0;
  logic pready_o, pslverr_o, op_ready_o, done_o, result_we_o, push_o;
  logic pop_o, io_we_o, perr;
  logic [2:0]  bit_i = 3'h0;
  logic [4:0]  io_waddr_o;
  logic [5:0]  io_addr_i = 6'h00;
  logic [7:0]  rd_val_i = 8'h00, rr_val_i = 8'h00, imm_i = 8'h00;
  logic [7:0]  status_flags_register_o, result_o, io_wmask_o, io_wval_o;
  logic [11:0] paddr_i = 12'h000, offset_i = 12'h000;
  logic [15:0] target_i = 16'h0000, z_ptr_i = 16'h0000, stack_i;
  logic [15:0] pc_o, ret_addr_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic [7:0]  fs [3] = '{8'h00, 8'hff, 8'h24};
  int          n_mismatch = 0, n_checks = 0, cycles = 0;
  bcx_pkg::bcx_op_t op_i = bcx_pkg::op_none;
  bcx_pkg::bcx_br_t br_sel_i = bcx_pkg::branch_on_equal;

  bcx_exec dut (.*);
  bcx_stack_model stk (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .push_i     (push_o),
    .pop_i      (pop_o),
    .ret_addr_i (ret_addr_o),
    .top_o      (stack_i)
  );

  always #5 clock_i = ~clock_i;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    q         = prdata_o;
    perr      = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // flags preset over the bus, then one operation and its cycle count
  task automatic run(input bcx_row_t r);
    int n;
    apb(1'b1, 12'h080, {24'h000000, r.fl});
    op_valid_i      <= 1'b1;
    op_i            <= r.op;
    rd_val_i        <= r.d;
    rr_val_i        <= r.k;
    imm_i           <= r.k;
    bit_i           <= r.b[2:0];
    io_addr_i       <= r.io[5:0];
    offset_i        <= r.t[11:0];
    target_i        <= r.t;
    z_ptr_i         <= r.t;
    next_two_word_i <= r.ntw[0];
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    #1;
    chk(pc_o, r.pc);
    chk(16'(status_flags_register_o), 16'(r.sr));
    chk(16'({done_o, result_we_o, io_we_o}),
        16'({1'b1, r.we[0], r.we[1]}));
    if (r.we[0]) chk(16'(result_o), 16'(r.res));
    if (r.we[1]) chk(16'(io_wval_o), 16'(r.res));
    if (r.we[1]) chk(16'({io_waddr_o, io_wmask_o}),
                     16'({r.io[4:0], 8'h01 << r.b[2:0]}));
    for (n = 1; op_ready_o !== 1'b1 && n < 9; n++) begin
      @(posedge clock_i);
      #1;
    end
    chk(16'(n), 16'(r.cyc));
    @(posedge clock_i);
  endtask

  function automatic logic br_taken(input int k, input logic [7:0] f);
    logic [2:0] ix [10];
    logic       v;
    ix = '{3'h5, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h5, 3'h6, 3'h3, 3'h7};
    v  = (k / 2 == 5) ? f[2] ^ f[3] : f[ix[k / 2]];
    return v == (~k[0] ^ (k / 2 == 3 || k / 2 == 5));
  endfunction

  initial begin
    bcx_row_t    tbl [26];
    logic [15:0] pc_e;
    logic        tk;
    tbl[0] = {bcx_pkg::mask_off_register_bits,
              96'hf30f000_0000_000_0001_f01041};
    tbl[1] = {bcx_pkg::add_one, 96'h7f00000_0000_010_0002_8010d1};
    tbl[2] = {bcx_pkg::subtract_one, 96'h0100000_0000_000_0003_001021};
    tbl[3] = {bcx_pkg::zero_or_sign_check,
              96'h8000000_0000_080_0004_000041};
    tbl[4] = {bcx_pkg::zero_register, 96'h5500000_0000_040_0005_001021};
    tbl[5] = {bcx_pkg::fill_register_with_ones,
              96'h1200000_0000_0f0_0006_ff10f1};
    tbl[6] = {bcx_pkg::flag_only_subtract,
              96'h1020000_0000_000_0007_000051};
    tbl[7] = {bcx_pkg::flag_only_subtract_with_borrow,
              96'h0505000_0000_030_0008_000251};
    tbl[8] = {bcx_pkg::flag_only_subtract_immediate,
              96'h8001000_0000_000_0009_000281};
    tbl[9] = {bcx_pkg::equal_compare_skip,
              96'h3333000_0000_001_000c_000003};
    tbl[10] = {bcx_pkg::skip_on_reg_bit_low,
               96'hf7f7300_0000_000_000e_000002};
    tbl[11] = {bcx_pkg::relative_goto, 96'h0_0ffe_000_000d_000002};
    tbl[12] = {bcx_pkg::pointer_goto, 96'h0_0200_000_0200_000002};
    tbl[13] = {bcx_pkg::absolute_goto, 96'h0_1234_000_1234_000003};
    tbl[14] = {bcx_pkg::relative_subroutine_entry,
               96'h0000000_0020_000_1255_000003};
    tbl[15] = {bcx_pkg::pointer_subroutine_entry,
               96'h0000000_0300_000_0300_000003};
    tbl[16] = {bcx_pkg::absolute_subroutine_entry,
               96'h0000000_0400_000_0400_000004};
    tbl[17] = {bcx_pkg::handler_exit, 96'h0_0000_000_0302_000804};
    tbl[18] = {bcx_pkg::subroutine_exit, 96'h0_0000_000_1256_000004};
    tbl[19] = {bcx_pkg::io_bit_set, 96'h0000205_0000_000_1257_c72002};
    tbl[20] = {bcx_pkg::io_bit_clear, 96'h0000005_0000_000_1258_c62002};
    tbl[21] = {bcx_pkg::skip_on_io_bit_high,
               96'h0000705_0000_000_125a_000002};
    tbl[22] = {bcx_pkg::io_bit_clear, 96'h0000120_0000_000_125b_000001};
    tbl[23] = {bcx_pkg::skip_on_io_bit_low,
               96'h0000005_0000_001_125e_000003};
    tbl[24] = {bcx_pkg::skip_on_reg_bit_high,
               96'h0080700_0000_001_1261_000003};
    tbl[25] = {bcx_pkg::skip_on_reg_bit_low,
               96'h0001000_0000_000_1262_000001};
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    apb(1'b1, 12'h014, 32'h000000c3);
    foreach (tbl[i]) run(tbl[i]);
    $display("operation table done");
    apb(1'b0, 12'h014, 32'h0);
    chk(q[15:0], 16'h00c6);
    apb(1'b0, 12'h088, 32'h0);
    chk(q[15:0], 16'h0001);
    apb(1'b1, 12'h088, 32'h1);
    apb(1'b0, 12'h088, 32'h0);
    chk(q[15:0], 16'h0000);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(16'(perr), 16'h0001);
    $display("register checks done");
    pc_e = tbl[25].pc;
    for (int k = 0; k < 20; k++) begin
      foreach (fs[j]) begin
        tk       = br_taken(k, fs[j]);
        pc_e     = pc_e + (tk ? 16'h0006 : 16'h0001);
        br_sel_i <= bcx_pkg::bcx_br_t'(k);
        run({bcx_pkg::conditional_branch, 44'h00005000005, fs[j], 4'h0,
             pc_e, 12'h000, fs[j], tk ? 4'h2 : 4'h1});
      end
    end
    $display("branch sweep done");
    reset_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk(pc_o, 16'h0000);
    chk(16'(status_flags_register_o), 16'h0000);
    chk(16'({op_ready_o, done_o}), 16'h0002);
    @(posedge clock_i);
    reset_i <= 1'b0;
    apb(1'b0, 12'h014, 32'h0);
    chk(q[15:0], 16'h0000);
    $display("mid-run reset done");
    close_out();
  end
endmodule
